// [pkg/rcf_map.svh]
// register offsets, field positions and reset values of the radio config block
`ifndef RCF_MAP_SVH
`define RCF_MAP_SVH
`define RCF_ADDR_CONFIG 8'h05
`define RCF_ADDR_SERCTL 8'h06
`define RCF_ADDR_IRQEN 8'h07
`define RCF_ADDR_STATUS 8'h08
`define RCF_ADDR_DATA_A 8'h09
`define RCF_ADDR_DATA_B 8'h0B
`define RCF_RST_CONFIG 8'h01
`define RCF_RST_SERCTL 8'h03
`define RCF_RST_IRQEN 8'h00
`define RCF_RST_STATUS 8'h00
`define RCF_WMASK_CONFIG 8'h1B
`define RCF_WMASK_SERCTL 8'h0F
`define RCF_BIT_RX_INV 4
`define RCF_BIT_TX_INV 3
`define RCF_BIT_BYTE_MODE 3
`define RCF_IRQ_OPEN_DRAIN 2'b11
`define RCF_IRQ_OPEN_SOURCE 2'b10
`define RCF_IRQ_PUSH_HIGH 2'b01
`define RCF_IRQ_PUSH_LOW 2'b00
`define RCF_LAST_BIT 3'h7
`endif

// [pkg/rcf_pkg.sv]
// types shared by the radio config and framing block
package rcf_pkg;
   typedef enum logic {RCF_IDLE, RCF_FRAME} rcf_phase_t;

   // one bit time from a correlator
   typedef struct packed {
      logic tick;
      logic valid;
      logic data;
   } rcf_corr_t;

   // one register access from the serial interface byte engine
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rcf_reg_req_t;

   typedef struct packed {
      rcf_phase_t phase;
      logic [7:0] shift;
      logic [2:0] cnt;
      logic [3:0] gap;
      logic [7:0] data;
      logic full;
      logic eof;
      logic ovf;
      logic unf;
      logic bit_out;
      logic bit_vld;
   } rcf_chan_st_t;

   typedef struct packed {
      logic [7:0] cfg;
      logic [7:0] ser;
      logic [7:0] ien;
      logic [7:0] stat;
      logic [7:0] rdata;
      logic irq_o;
      logic irq_oe;
      logic tx_bit;
      logic [2:0] dio_s;
      logic [2:0] dv_s;
      logic dio_lvl;
      logic dv_lvl;
      logic pin_o;
      logic pin_v;
      logic pin_oe;
   } rcf_top_st_t;
endpackage : rcf_pkg

// [hdl/rcf_rx_chan.sv]
// receive framer for one correlator channel: byte assembly, end of frame, data register
`timescale 1ns/1ps
`default_nettype none
`include "rcf_map.svh"
module rcf_rx_chan
   import rcf_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic rx_mode,
   input wire logic byte_mode,
   input wire logic rx_inv,
   input wire logic [2:0] eof_len,
   input wire rcf_corr_t corr,
   input wire logic data_rd,
   output logic [7:0] data,
   output logic full,
   output logic eof,
   output logic ovf,
   output logic unf,
   output logic bit_out,
   output logic bit_vld
);
   rcf_chan_st_t s_q;
   rcf_chan_st_t s_d;
   logic rx_bit;
   logic move;
   logic [7:0] mv_data;
   logic [7:0] sh;
   logic [3:0] gap_n;

   // framing: count bits into bytes, count empty bit times after a frame started
   always_comb begin
      s_d = s_q;
      s_d.eof = 1'b0;
      s_d.ovf = 1'b0;
      s_d.unf = 1'b0;
      s_d.bit_vld = 1'b0;
      move = 1'b0;
      mv_data = s_q.shift;
      rx_bit = corr.data ^ rx_inv;
      sh = {s_q.shift[6:0], rx_bit};
      gap_n = s_q.gap + 4'h1;
      if (data_rd) begin
         if (!s_q.full) begin
            s_d.unf = 1'b1;
         end
         s_d.full = 1'b0;
      end
      if (!rx_mode) begin
         // leaving receive abandons any half frame
         s_d.phase = RCF_IDLE;
         s_d.cnt = 3'h0;
         s_d.gap = 4'h0;
      end else if (corr.tick) begin
         if (corr.valid) begin
            s_d.phase = RCF_FRAME;
            s_d.gap = 4'h0;
            s_d.bit_out = rx_bit;
            s_d.bit_vld = 1'b1;
            s_d.shift = sh;
            if (s_q.cnt == `RCF_LAST_BIT) begin
               move = 1'b1;
               mv_data = sh;
               s_d.cnt = 3'h0;
               s_d.shift = 8'h00; // stale bits would leak into a later partial byte
            end else begin
               s_d.cnt = s_q.cnt + 3'h1;
            end
         end else if (s_q.phase == RCF_FRAME) begin
            if (gap_n > {1'b0, eof_len}) begin
               s_d.eof = 1'b1;
               s_d.phase = RCF_IDLE;
               s_d.gap = 4'h0;
               if (s_q.cnt != 3'h0) begin
                  move = 1'b1;
                  s_d.cnt = 3'h0;
                  s_d.shift = 8'h00;
               end
            end else begin
               s_d.gap = gap_n;
            end
         end
      end
      // a new byte wins over a read in the same cycle
      if (move && byte_mode) begin
         if (s_q.full && !data_rd) begin
            s_d.ovf = 1'b1;
         end
         s_d.data = mv_data;
         s_d.full = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign data = s_q.data;
   assign full = s_q.full;
   assign eof = s_q.eof;
   assign ovf = s_q.ovf;
   assign unf = s_q.unf;
   assign bit_out = s_q.bit_out;
   assign bit_vld = s_q.bit_vld;

   chk_rx_invert: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $past(rx_mode && corr.tick && corr.valid) |-> bit_out == ($past(corr.data) ^ $past(rx_inv)))
      else $error("received bit not inverted as configured");
   chk_eof_zero_len: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rx_mode && corr.tick && !corr.valid && s_q.phase == RCF_FRAME && eof_len == 3'h0 |=> eof)
      else $error("zero gap length did not end frame on first empty bit");
   chk_eof_in_frame: assert property (@(posedge ref_clk) disable iff (!rst_n)
      eof |-> $past(s_q.phase) == RCF_FRAME && $past(s_q.gap) == {1'b0, $past(eof_len)})
      else $error("end of frame without a frame or at the wrong gap count");
   chk_full_on_move: assert property (@(posedge ref_clk) disable iff (!rst_n)
      byte_mode && rx_mode && corr.tick && corr.valid && s_q.cnt == `RCF_LAST_BIT |=> full && data == $past(sh))
      else $error("complete byte not placed in data register");
   chk_ovf_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ovf |-> $past(s_q.full) && !$past(data_rd) && full)
      else $error("overflow flagged without unread data");
   chk_unf_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
      data_rd && !full |=> unf)
      else $error("read of empty data register not flagged");
endmodule : rcf_rx_chan
`default_nettype wire

// [hdl/rcf_radio_cfg.sv]
// configuration registers, receive framing and interrupt pin of the radio modem
`timescale 1ns/1ps
`default_nettype none
`include "rcf_map.svh"
// Behaviour
// - config bit 4 inverts received data
// - config bit 3 inverts transmit data
// - two-bit field picks interrupt pin drive
// - control bit 3: byte registers, else pins
// - gap field sets empty bits before end
// - gap counts only in receive, after valid
// - end of frame moves pending data, interrupts
// - zero gap ends at first empty bit
// - status read clears end of frame flag
// - overflow when unread data gets overwritten
// - underflow when reading an empty register
// - full on byte or on end of frame with bits pending
module rcf_radio_cfg
   import rcf_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire rcf_reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   input wire logic rx_mode,
   input wire rcf_corr_t corr_a,
   input wire rcf_corr_t corr_b,
   input wire logic tx_req,
   input wire logic tx_ser_bit,
   output logic tx_bit,
   input wire logic serial_data_pin_i,
   output logic serial_data_pin_o,
   output logic serial_data_pin_oe,
   input wire logic serial_data_valid_pin_i,
   output logic serial_data_valid_pin_o,
   output logic serial_data_valid_pin_oe,
   output logic irq_pin_o,
   output logic irq_pin_oe
);
   rcf_top_st_t s_q;
   rcf_top_st_t s_d;
   logic byte_mode;
   logic rd_a;
   logic rd_b;
   logic rd_stat;
   logic [7:0] data_a;
   logic [7:0] data_b;
   logic full_a;
   logic full_b;
   logic eof_a;
   logic eof_b;
   logic ovf_a;
   logic ovf_b;
   logic unf_a;
   logic unf_b;
   logic bit_a;
   logic vld_a;
   logic [7:0] events;
   logic [7:0] stat_view;
   logic irq_lvl;
   logic tx_src;

   assign byte_mode = s_q.ser[`RCF_BIT_BYTE_MODE];

   // read strobes have side effects on the channels and status
   assign rd_a = reg_req.rd && reg_req.addr == `RCF_ADDR_DATA_A;
   assign rd_b = reg_req.rd && reg_req.addr == `RCF_ADDR_DATA_B;
   assign rd_stat = reg_req.rd && reg_req.addr == `RCF_ADDR_STATUS;

   rcf_rx_chan u_chan_a (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .rx_mode(rx_mode),
      .byte_mode(byte_mode),
      .rx_inv(s_q.cfg[`RCF_BIT_RX_INV]),
      .eof_len(s_q.ser[2:0]),
      .corr(corr_a),
      .data_rd(rd_a),
      .data(data_a),
      .full(full_a),
      .eof(eof_a),
      .ovf(ovf_a),
      .unf(unf_a),
      .bit_out(bit_a),
      .bit_vld(vld_a)
   );

   rcf_rx_chan u_chan_b (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .rx_mode(rx_mode),
      .byte_mode(byte_mode),
      .rx_inv(s_q.cfg[`RCF_BIT_RX_INV]),
      .eof_len(s_q.ser[2:0]),
      .corr(corr_b),
      .data_rd(rd_b),
      .data(data_b),
      .full(full_b),
      .eof(eof_b),
      .ovf(ovf_b),
      .unf(unf_b),
      .bit_out(),
      .bit_vld()
   );

   // sticky events; full bits follow the data registers directly
   assign events = {unf_b, ovf_b, eof_b, 1'b0, unf_a, ovf_a, eof_a, 1'b0};
   assign stat_view = {s_q.stat[7:5], full_b, s_q.stat[3:1], full_a};
   assign irq_lvl = |(stat_view & s_q.ien);
   // bit-serial transmit only takes a pin bit the host marked valid
   assign tx_src = byte_mode ? tx_ser_bit : s_q.dio_lvl;

   // register file, pin synchronisers, transmit path and pin drivers
   always_comb begin
      s_d = s_q;
      // three-stage synchronisers; a level counts once stages two and three agree
      s_d.dio_s = {s_q.dio_s[1:0], serial_data_pin_i};
      s_d.dv_s = {s_q.dv_s[1:0], serial_data_valid_pin_i};
      if (s_q.dio_s[1] == s_q.dio_s[2]) begin
         s_d.dio_lvl = s_q.dio_s[2];
      end
      if (s_q.dv_s[1] == s_q.dv_s[2]) begin
         s_d.dv_lvl = s_q.dv_s[2];
      end
      // writes; reserved bits are dropped so they always read zero
      if (reg_req.wr) begin
         case (reg_req.addr)
            `RCF_ADDR_CONFIG: s_d.cfg = reg_req.wdata & `RCF_WMASK_CONFIG;
            `RCF_ADDR_SERCTL: s_d.ser = reg_req.wdata & `RCF_WMASK_SERCTL;
            `RCF_ADDR_IRQEN: s_d.ien = reg_req.wdata;
            default: s_d.ien = s_q.ien;
         endcase
      end
      // status read clears the sticky flags; a new event in that cycle survives
      if (rd_stat) begin
         s_d.stat = `RCF_RST_STATUS;
      end
      s_d.stat = s_d.stat | events;
      if (reg_req.rd) begin
         case (reg_req.addr)
            `RCF_ADDR_CONFIG: s_d.rdata = s_q.cfg;
            `RCF_ADDR_SERCTL: s_d.rdata = s_q.ser;
            `RCF_ADDR_IRQEN: s_d.rdata = s_q.ien;
            `RCF_ADDR_STATUS: s_d.rdata = stat_view;
            `RCF_ADDR_DATA_A: s_d.rdata = data_a;
            `RCF_ADDR_DATA_B: s_d.rdata = data_b;
            default: s_d.rdata = 8'h00;
         endcase
      end
      if (tx_req && (byte_mode || s_q.dv_lvl)) begin
         s_d.tx_bit = tx_src ^ s_q.cfg[`RCF_BIT_TX_INV];
      end
      // bit-serial receive: channel A bits leave on the pins, device drives only then
      s_d.pin_oe = rx_mode && !byte_mode;
      s_d.pin_o = bit_a;
      s_d.pin_v = vld_a;
      case (s_q.cfg[1:0])
         `RCF_IRQ_OPEN_DRAIN: begin
            s_d.irq_o = 1'b0;
            s_d.irq_oe = irq_lvl;
         end
         `RCF_IRQ_OPEN_SOURCE: begin
            s_d.irq_o = 1'b1;
            s_d.irq_oe = irq_lvl;
         end
         `RCF_IRQ_PUSH_HIGH: begin
            s_d.irq_o = irq_lvl;
            s_d.irq_oe = 1'b1;
         end
         default: begin
            s_d.irq_o = !irq_lvl;
            s_d.irq_oe = 1'b1;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.cfg <= `RCF_RST_CONFIG;
         s_q.ser <= `RCF_RST_SERCTL;
         s_q.ien <= `RCF_RST_IRQEN;
         s_q.irq_oe <= 1'b1; // default push-pull high idles low
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata = s_q.rdata;
   assign tx_bit = s_q.tx_bit;
   assign serial_data_pin_o = s_q.pin_o;
   assign serial_data_pin_oe = s_q.pin_oe;
   assign serial_data_valid_pin_o = s_q.pin_v;
   assign serial_data_valid_pin_oe = s_q.pin_oe;
   assign irq_pin_o = s_q.irq_o;
   assign irq_pin_oe = s_q.irq_oe;

   chk_irq_open_drain: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_q.cfg[1:0] == 2'b11 |=> !irq_pin_o && irq_pin_oe == $past(irq_lvl))
      else $error("open drain interrupt drive wrong");
   chk_irq_push_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_q.cfg[1:0] == 2'b00 |=> irq_pin_oe && irq_pin_o == !$past(irq_lvl))
      else $error("inverted push-pull interrupt drive wrong");
   chk_irq_gating: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_q.ien == 8'h00 && s_q.cfg[1:0] == 2'b01 |=> !irq_pin_o)
      else $error("interrupt raised with all enables off");
   chk_tx_invert: assert property (@(posedge ref_clk) disable iff (!rst_n)
      tx_req && byte_mode |=> tx_bit == ($past(tx_ser_bit) ^ $past(s_q.cfg[3])))
      else $error("transmit bit not inverted as configured");
   chk_stat_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rd_stat && !eof_a && !eof_b |=> s_q.stat[1] == 1'b0 && s_q.stat[5] == 1'b0)
      else $error("status read did not clear end of frame flags");
   chk_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
      reg_req.wr |=> s_q.cfg[7:5] == 3'h0 && s_q.cfg[2] == 1'b0 && s_q.ser[7:4] == 4'h0)
      else $error("reserved bits hold a one");
   chk_pins_mode: assert property (@(posedge ref_clk) disable iff (!rst_n)
      byte_mode |=> !serial_data_pin_oe)
      else $error("serial pins driven in byte mode");
endmodule : rcf_radio_cfg
`default_nettype wire

// [tb/rcf_host_model.sv]
// host side model: single byte register accesses on the request port
`timescale 1ns/1ps
`default_nettype none
`include "rcf_map.svh"
module rcf_host_model
   import rcf_pkg::*;
(
   input wire logic ref_clk,
   input wire logic [7:0] reg_rdata,
   output var rcf_reg_req_t reg_req
);
   // idle bus from time zero
   initial begin
      reg_req = '0;
   end

   // one write, reserved bits always sent as zero
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] m;
      m = (a == `RCF_ADDR_CONFIG) ? `RCF_WMASK_CONFIG : 8'hFF;
      m = (a == `RCF_ADDR_SERCTL) ? `RCF_WMASK_SERCTL : m;
      @(posedge ref_clk) #1;
      reg_req = {1'b1, 1'b0, a, d & m};
      @(posedge ref_clk) #1;
      reg_req.wr = 1'b0;
   endtask : wr

   // one read; data is registered at the taking edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk) #1;
      reg_req = {1'b0, 1'b1, a, 8'h00};
      @(posedge ref_clk) #1;
      reg_req.rd = 1'b0;
      d = reg_rdata;
   endtask : rd
endmodule : rcf_host_model
`default_nettype wire

// [tb/radio_config_and_framing_ctl_bench.sv]
// self-checking bench of the radio config and framing block
`timescale 1ns/1ps
`default_nettype none
module radio_config_and_framing_ctl_bench;
   import rcf_pkg::*;
   logic ref_clk, rst_n, rx_mode, tx_req, tx_ser_bit, tx_bit, pin_dat, pin_val;
   logic dat_o, dat_oe, val_o, val_oe, irq_pin_o, irq_pin_oe;
   logic [7:0] reg_rdata;
   rcf_reg_req_t reg_req;
   rcf_corr_t corr_a, corr_b;
   int err_total = 0;
   int n_compared = 0;
   logic [23:0] rows [4] = '{24'h05_FF1B, 24'h06_FF0F, 24'h07_FFFF, 24'h20_5500};
   logic [1:0] m;
   logic [7:0] rd_junk;

   rcf_host_model u_host (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_req(reg_req));

   rcf_radio_cfg u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .rx_mode(rx_mode), .corr_a(corr_a), .corr_b(corr_b), .tx_req(tx_req), .tx_ser_bit(tx_ser_bit),
      .tx_bit(tx_bit), .serial_data_pin_i(dat_oe ? dat_o : pin_dat), .serial_data_pin_o(dat_o),
      .serial_data_pin_oe(dat_oe), .serial_data_valid_pin_i(val_oe ? val_o : pin_val),
      .serial_data_valid_pin_o(val_o), .serial_data_valid_pin_oe(val_oe), .irq_pin_o(irq_pin_o),
      .irq_pin_oe(irq_pin_oe));

   // free running 100 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic stop_test;
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // masked register read compare
   task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] msk);
      logic [7:0] d;
      u_host.rd(a, d);
      chk(d & msk, e);
   endtask : rdc

   // one bit time on channel a
   task automatic tick(input logic v, input logic d);
      @(posedge ref_clk) #1;
      corr_a = {1'b1, v, d};
      @(posedge ref_clk) #1;
      corr_a.tick = 1'b0;
   endtask : tick

   // one cycle transmit request
   task automatic tx_pulse;
      @(posedge ref_clk) #1;
      tx_req = 1'b1;
      @(posedge ref_clk) #1;
      tx_req = 1'b0;
   endtask : tx_pulse

   // hang guard, far beyond the few hundred cycles needed
   initial begin
      #300000;
      err_total++;
      stop_test();
   end

   initial begin
      {rst_n, rx_mode, tx_req, tx_ser_bit, pin_dat, pin_val} = '0;
      corr_a = '0;
      corr_b = '0;
      repeat (10) @(posedge ref_clk);
      #1 rst_n = 1'b1;
      chk({irq_pin_oe, irq_pin_o, dat_oe, val_oe, tx_bit}, 8'h10);
      rdc(8'h05, 8'h01, 8'hFF);
      rdc(8'h06, 8'h03, 8'hFF);
      rdc(8'h07, 8'h00, 8'hFF);
      // plain write then read back rows, last one unmapped
      foreach (rows[i]) begin
         u_host.wr(rows[i][23:16], rows[i][15:8]);
         rdc(rows[i][23:16], rows[i][7:0], 8'hFF);
      end
      // short frame, zero gap; leading empty ticks must not end a frame
      u_host.wr(8'h07, 8'h00);
      u_host.wr(8'h05, 8'h01);
      u_host.wr(8'h06, 8'h08);
      rx_mode = 1'b1;
      tick(1'b0, 1'b1);
      tick(1'b0, 1'b1);
      rdc(8'h08, 8'h00, 8'hFF);
      tick(1'b1, 1'b1);
      tick(1'b1, 1'b0);
      tick(1'b1, 1'b1);
      tick(1'b0, 1'b0);
      rdc(8'h08, 8'h03, 8'hFF);
      rdc(8'h09, 8'h05, 8'hFF);
      rdc(8'h09, 8'h00, 8'h00);
      rdc(8'h08, 8'h08, 8'h0F);
      // inverted receive, gap of two empty bits
      u_host.wr(8'h05, 8'h11);
      u_host.wr(8'h06, 8'h0A);
      for (int i = 7; i >= 0; i--) tick(1'b1, 8'hA5 >> i);
      rdc(8'h09, 8'h5A, 8'hFF);
      tick(1'b0, 1'b0);
      tick(1'b0, 1'b0);
      rdc(8'h08, 8'h00, 8'h02);
      tick(1'b0, 1'b0);
      rdc(8'h08, 8'h02, 8'h02);
      // two unread bytes overrun the data register
      repeat (16) tick(1'b1, 1'b0);
      rdc(8'h08, 8'h04, 8'h04);
      rdc(8'h09, 8'hFF, 8'hFF);
      // pending underflow drives the pin in every mode
      rdc(8'h09, 8'h00, 8'h00);
      u_host.wr(8'h07, 8'h08);
      for (int k = 0; k < 4; k++) begin
         m = k;
         u_host.wr(8'h05, {6'h00, m});
         repeat (2) @(posedge ref_clk) #1;
         chk({irq_pin_oe, irq_pin_o}, {1'b1, m[1] ^ m[0]});
      end
      u_host.wr(8'h05, 8'h01);
      u_host.wr(8'h07, 8'hF7);
      repeat (2) @(posedge ref_clk) #1;
      chk(irq_pin_o, 1'b0);
      u_host.wr(8'h07, 8'h08);
      rdc(8'h08, 8'h08, 8'h08);
      repeat (2) @(posedge ref_clk) #1;
      chk(irq_pin_o, 1'b0);
      // transmit inversion over both polarities
      u_host.wr(8'h06, 8'h08);
      for (int k = 0; k < 4; k++) begin
         m = k;
         u_host.wr(8'h05, {4'h0, m[1], 3'h1});
         tx_ser_bit = m[0];
         tx_pulse();
         chk(tx_bit, m[1] ^ m[0]);
      end
      // channel b: three bits then an empty tick land in its own register
      u_host.wr(8'h07, 8'h30);
      for (int i = 0; i < 4; i++) begin
         @(posedge ref_clk) #1;
         corr_b = {1'b1, i < 3, 1'b1};
         @(posedge ref_clk) #1;
         corr_b.tick = 1'b0;
      end
      repeat (2) @(posedge ref_clk) #1;
      chk(irq_pin_o, 1'b1);
      rdc(8'h08, 8'h30, 8'hF0);
      rdc(8'h0B, 8'h07, 8'hFF);
      u_host.rd(8'h0B, rd_junk);
      rdc(8'h08, 8'h80, 8'hF0);
      repeat (2) @(posedge ref_clk) #1;
      chk(irq_pin_o, 1'b0);
      // bit-serial mode: receive appears on the pins
      u_host.wr(8'h05, 8'h01);
      u_host.wr(8'h06, 8'h00);
      tick(1'b1, 1'b1);
      for (int k = 0; k < 6 && val_o !== 1'b1; k++) @(posedge ref_clk) #1;
      chk({dat_oe, val_oe, val_o, dat_o}, 8'h0F);
      // bit-serial transmit takes the synced pin level
      rx_mode = 1'b0;
      pin_dat = 1'b1;
      pin_val = 1'b1;
      repeat (6) @(posedge ref_clk);
      tx_pulse();
      chk(tx_bit, 1'b1);
      stop_test();
   end
endmodule : radio_config_and_framing_ctl_bench
`default_nettype wire
